// ### hdl/tafl_pkg.sv
// tafl_pkg: register map, field layouts, reset values and timing counts
// assumes a 50 MHz system clock and a plain strobe register port
package tafl_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ          = 50000000;
	localparam int SEC_NS          = 1000000000;
	localparam int CLK_NS          = SEC_NS / CLK_HZ;
	localparam int SEC_CYCLES      = SEC_NS / CLK_NS;
	localparam logic [11:0] DLY_MAX_S = 12'hE10; // 3600 s

	// ------------------------------------------------------------------
	// temperature limits, signed tenths of a degree
	// ------------------------------------------------------------------
	localparam logic signed [15:0] TLO_MIN = 16'shFF38; // -20.0
	localparam logic signed [15:0] TLO_MAX = 16'sh02BB; // 69.9
	localparam logic signed [15:0] THI_MIN = 16'shFF39; // -19.9
	localparam logic signed [15:0] THI_MAX = 16'sh02BC; // 70.0
	localparam logic [9:0] FS_MAX_PM      = 10'h3E8;   // 100.0 %

	// ------------------------------------------------------------------
	// register offsets (word index)
	// ------------------------------------------------------------------
	localparam logic [4:0] R_TCTRL   = 5'h00;
	localparam logic [4:0] R_TLO     = 5'h01;
	localparam logic [4:0] R_THI     = 5'h02;
	localparam logic [4:0] R_TACT    = 5'h03;
	localparam logic [4:0] R_TPON    = 5'h04;
	localparam logic [4:0] R_TSTAT   = 5'h05;
	localparam logic [4:0] R_TOT0    = 5'h08; // per totalizer block base
	localparam logic [4:0] R_TOT1    = 5'h10;
	// offsets inside a totalizer block
	localparam logic [2:0] T_CTRL    = 3'h0;
	localparam logic [2:0] T_START   = 3'h1;
	localparam logic [2:0] T_VOL     = 3'h2;
	localparam logic [2:0] T_PON     = 3'h3;
	localparam logic [2:0] T_ARDLY   = 3'h4;
	localparam logic [2:0] T_VALUE   = 3'h5;
	localparam logic [2:0] T_CMD     = 3'h6;
	localparam logic [4:0] R_LOCK    = 5'h18;

	// control field positions
	localparam int F_EN      = 0;
	localparam int F_LATCH   = 1;
	localparam int F_ARST    = 1;
	localparam int F_CLR     = 0; // command: clear
	localparam int F_LOCK    = 0;
	localparam logic [15:0] LOCK_KEY = 16'h544C; // 'T','L' argument pair

	typedef struct packed {
		logic        en;
		logic        latch;
		logic signed [15:0] lo;
		logic signed [15:0] hi;
		logic [11:0] act_dly;
		logic [11:0] pon_dly;
	} tafl_tcfg_t;

	typedef struct packed {
		logic        en;
		logic        arst;
		logic [9:0]  start_pm;
		logic [31:0] vol;
		logic [11:0] pon_dly;
		logic [11:0] ar_dly;
	} tafl_ccfg_t;

endpackage

// ### hdl/tafl_top.sv
// tafl_top: temperature alarm with delays and latch, two flow totalizers
// assumes synchronous inputs, one 50 MHz clock, plain strobe register port
// Functional notes
// - enabled alarm raises low event when reading falls below low limit
// - enabled alarm raises high event when reading exceeds high limit
// - low limit in tenths, -20.0 to 69.9 degrees
// - high limit in tenths, -19.9 to 70.0 degrees
// - alarm enable defaults off; no events while off
// - alert marker toggles once per second during active alarm
// - violation must persist the action delay before event asserts
// - alarm inactive after power-up until its power-on delay elapses
// - latch keeps relay on after firing; otherwise relay follows alarm
// - two independent totalizers integrate mass flow rate
// - totals saved every second and reloaded at power-up
// - totalizer enable defaults off; disabled totalizer holds
// - accumulate only when flow at or above start threshold
// - action event when total reaches action volume; zero disables
// - totalizer waits its own power-on delay after power-up
// - auto reset clears total on reaching action volume
// - after auto reset wait the batch delay before accumulating
// - operator reset clears selected total and gives confirmation
// - maintenance push button also resets the totals
// - reset lock ignores operator and push button resets, not auto reset; lock set only by keyed command
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module tafl_top
	import tafl_pkg::*;
#(
	parameter int SEC_CNT = SEC_CYCLES
) (
	// clock and reset
	input  wire logic               mclk_in,
	input  wire logic               reset_in,
	// register port
	input  wire logic [4:0]         addr_in,
	input  wire logic [31:0]        wdata_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	output logic      [31:0]        rdata_out,
	// process inputs
	input  wire logic signed [15:0] temp_in,
	input  wire logic [9:0]         flow_pm_in,
	input  wire logic [15:0]        flow_rate_in,
	input  wire logic               maint_btn_in,
	// nonvolatile store of totals
	input  wire logic [31:0]        nv_tot0_in,
	input  wire logic [31:0]        nv_tot1_in,
	output logic                    nv_save_out,
	output logic      [63:0]        nv_data_out,
	// outputs
	output logic                    switched_output_relay_out,
	output logic                    tlo_event_out,
	output logic                    thi_event_out,
	output logic                    alert_marker_out,
	output logic      [1:0]         tot_event_out,
	output logic      [1:0]         rst_confirm_out
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic signed [15:0] clamp_s(
		input logic signed [15:0] v,
		input logic signed [15:0] lo,
		input logic signed [15:0] hi);
		clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [11:0] clamp_d(input logic [31:0] v);
		clamp_d = (v > 32'(DLY_MAX_S)) ? DLY_MAX_S : v[11:0];
	endfunction

	// ------------------------------------------------------------------
	// one second time base
	// ------------------------------------------------------------------
	logic [25:0] pre_r;
	logic        tick_r;
	logic [11:0] up_s_r;   // seconds since power-up, saturates

	// second strobe
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			pre_r  <= 26'h0000000;
			tick_r <= 1'b0;
		end else if (pre_r == 26'(SEC_CNT - 1)) begin
			pre_r  <= 26'h0000000;
			tick_r <= 1'b1;
		end else begin
			pre_r  <= pre_r + 26'h0000001;
			tick_r <= 1'b0;
		end
	end

	// uptime counter
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in)
			up_s_r <= 12'h000;
		else if (tick_r && up_s_r != DLY_MAX_S)
			up_s_r <= up_s_r + 12'h001;
	end

	// ------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------
	tafl_tcfg_t tcfg_r;
	tafl_ccfg_t ccfg_r [2];
	logic       lock_r;
	logic [1:0] clr_req;
	logic [31:0] tot_r [2];

	// temperature settings
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			tcfg_r.en      <= 1'b0;
			tcfg_r.latch   <= 1'b0;
			tcfg_r.lo      <= TLO_MIN;
			tcfg_r.hi      <= THI_MAX;
			tcfg_r.act_dly <= 12'h000;
			tcfg_r.pon_dly <= 12'h000;
		end else if (wr_in) begin
			unique case (addr_in)
				R_TCTRL: begin
					tcfg_r.en    <= wdata_in[F_EN];
					tcfg_r.latch <= wdata_in[F_LATCH];
				end
				R_TLO: tcfg_r.lo <= clamp_s(wdata_in[15:0], TLO_MIN, TLO_MAX);
				R_THI: tcfg_r.hi <= clamp_s(wdata_in[15:0], THI_MIN, THI_MAX);
				R_TACT: tcfg_r.act_dly <= clamp_d(wdata_in);
				R_TPON: tcfg_r.pon_dly <= clamp_d(wdata_in);
				default: ;
			endcase
		end
	end

	// reset lock, keyed write only
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in)
			lock_r <= 1'b0;
		else if (wr_in && addr_in == R_LOCK && wdata_in[31:16] == LOCK_KEY)
			lock_r <= wdata_in[F_LOCK];
	end

	// ------------------------------------------------------------------
	// temperature alarm
	// ------------------------------------------------------------------
	logic        t_armed;
	logic        lo_viol;
	logic        hi_viol;
	logic [11:0] lo_cnt_r;
	logic [11:0] hi_cnt_r;
	logic        lo_ev_r;
	logic        hi_ev_r;
	logic        relay_hold_r;

	assign t_armed = tcfg_r.en && (up_s_r >= tcfg_r.pon_dly);
	assign lo_viol = t_armed && (temp_in < tcfg_r.lo);
	assign hi_viol = t_armed && (temp_in > tcfg_r.hi);

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			lo_cnt_r <= 12'h000;
			hi_cnt_r <= 12'h000;
		end else begin
			if (!lo_viol)
				lo_cnt_r <= 12'h000;
			else if (tick_r && lo_cnt_r != DLY_MAX_S)
				lo_cnt_r <= lo_cnt_r + 12'h001;
			if (!hi_viol)
				hi_cnt_r <= 12'h000;
			else if (tick_r && hi_cnt_r != DLY_MAX_S)
				hi_cnt_r <= hi_cnt_r + 12'h001;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			lo_ev_r <= 1'b0;
			hi_ev_r <= 1'b0;
		end else begin
			lo_ev_r <= lo_viol && (lo_cnt_r >= tcfg_r.act_dly);
			hi_ev_r <= hi_viol && (hi_cnt_r >= tcfg_r.act_dly);
		end
	end

	// latched relay hold, cleared by dropping latch mode
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in)
			relay_hold_r <= 1'b0;
		else if (lo_ev_r || hi_ev_r)
			relay_hold_r <= tcfg_r.latch;
		else if (!tcfg_r.latch)
			relay_hold_r <= 1'b0;
	end

	// relay and event outputs
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			switched_output_relay_out <= 1'b0;
			tlo_event_out             <= 1'b0;
			thi_event_out             <= 1'b0;
		end else begin
			switched_output_relay_out <= lo_ev_r || hi_ev_r || relay_hold_r;
			tlo_event_out             <= lo_ev_r;
			thi_event_out             <= hi_ev_r;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in)
			alert_marker_out <= 1'b0;
		else if (!(lo_ev_r || hi_ev_r))
			alert_marker_out <= 1'b0;
		else if (tick_r)
			alert_marker_out <= !alert_marker_out;
	end

	// ------------------------------------------------------------------
	// totalizers
	// ------------------------------------------------------------------
	logic        loaded_r;
	logic [1:0]  btn_q_r;
	logic [1:0]  confirm_r;
	logic [1:0]  tev_r;

	// push button edge, ignored under lock
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in)
			btn_q_r <= 2'b00;
		else
			btn_q_r <= {btn_q_r[0], maint_btn_in};
	end

	// reload flag for first cycle after reset
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in)
			loaded_r <= 1'b0;
		else
			loaded_r <= 1'b1;
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tot
			logic [4:0]  base;
			logic [11:0] ar_cnt_r;
			logic        ar_wait_r;
			logic        run;
			logic        hit;
			logic [31:0] sum;
			assign base = (g == 0) ? R_TOT0 : R_TOT1;
			assign hit  = (ccfg_r[g].vol != 32'h00000000) &&
			              (tot_r[g] >= ccfg_r[g].vol);
			assign run  = ccfg_r[g].en && !ar_wait_r &&
			              (flow_pm_in >= ccfg_r[g].start_pm) &&
			              (up_s_r >= ccfg_r[g].pon_dly);
			assign sum  = tot_r[g] + {16'h0000, flow_rate_in};
			assign clr_req[g] = !lock_r &&
				((wr_in && addr_in == (base | 5'(T_CMD)) && wdata_in[F_CLR]) ||
				 (btn_q_r == 2'b01));

			// settings
			always_ff @(posedge mclk_in or posedge reset_in) begin
				if (reset_in) begin
					ccfg_r[g].en       <= 1'b0;
					ccfg_r[g].arst     <= 1'b0;
					ccfg_r[g].start_pm <= 10'h000;
					ccfg_r[g].vol      <= 32'h00000000;
					ccfg_r[g].pon_dly  <= 12'h000;
					ccfg_r[g].ar_dly   <= 12'h000;
				end else if (wr_in && addr_in[4:3] == base[4:3]) begin
					unique case (addr_in[2:0])
						T_CTRL: begin
							ccfg_r[g].en   <= wdata_in[F_EN];
							ccfg_r[g].arst <= wdata_in[F_ARST];
						end
						T_START: ccfg_r[g].start_pm <=
							(wdata_in[9:0] > FS_MAX_PM) ? FS_MAX_PM : wdata_in[9:0];
						T_VOL:   ccfg_r[g].vol     <= wdata_in;
						T_PON:   ccfg_r[g].pon_dly <= clamp_d(wdata_in);
						T_ARDLY: ccfg_r[g].ar_dly  <= clamp_d(wdata_in);
						default: ;
					endcase
				end
			end

			// integrate once per second; auto clear
			always_ff @(posedge mclk_in or posedge reset_in) begin
				if (reset_in)
					tot_r[g] <= 32'h00000000;
				else if (!loaded_r)
					tot_r[g] <= (g == 0) ? nv_tot0_in : nv_tot1_in;
				else if (clr_req[g] || (hit && ccfg_r[g].arst))
					tot_r[g] <= 32'h00000000;
				else if (tick_r && run)
					tot_r[g] <= sum;
			end

			always_ff @(posedge mclk_in or posedge reset_in) begin
				if (reset_in) begin
					ar_wait_r <= 1'b0;
					ar_cnt_r  <= 12'h000;
				end else if (hit && ccfg_r[g].arst) begin
					ar_wait_r <= 1'b1;
					ar_cnt_r  <= 12'h000;
				end else if (ar_wait_r && ar_cnt_r >= ccfg_r[g].ar_dly) begin
					ar_wait_r <= 1'b0;
				end else if (ar_wait_r && tick_r) begin
					ar_cnt_r  <= ar_cnt_r + 12'h001;
				end
			end

			always_ff @(posedge mclk_in or posedge reset_in) begin
				if (reset_in) begin
					tev_r[g]     <= 1'b0;
					confirm_r[g] <= 1'b0;
				end else begin
					tev_r[g]     <= hit;
					confirm_r[g] <= clr_req[g];
				end
			end
		end
	endgenerate

	// outputs of totalizers
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			tot_event_out   <= 2'b00;
			rst_confirm_out <= 2'b00;
		end else begin
			tot_event_out   <= tev_r;
			rst_confirm_out <= confirm_r;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			nv_save_out <= 1'b0;
			nv_data_out <= 64'h0000000000000000;
		end else begin
			nv_save_out <= tick_r && loaded_r;
			nv_data_out <= {tot_r[1], tot_r[0]};
		end
	end

	// ------------------------------------------------------------------
	// register read
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in)
			rdata_out <= 32'h00000000;
		else if (rd_in) begin
			unique case (addr_in)
				R_TCTRL: rdata_out <= {30'h0, tcfg_r.latch, tcfg_r.en};
				R_TLO:   rdata_out <= {{16{tcfg_r.lo[15]}}, tcfg_r.lo};
				R_THI:   rdata_out <= {{16{tcfg_r.hi[15]}}, tcfg_r.hi};
				R_TACT:  rdata_out <= {20'h0, tcfg_r.act_dly};
				R_TPON:  rdata_out <= {20'h0, tcfg_r.pon_dly};
				R_TSTAT: rdata_out <= {29'h0, relay_hold_r, hi_ev_r, lo_ev_r};
				R_LOCK:  rdata_out <= {31'h0, lock_r};
				R_TOT0 | 5'(T_VALUE): rdata_out <= tot_r[0];
				R_TOT1 | 5'(T_VALUE): rdata_out <= tot_r[1];
				R_TOT0 | 5'(T_VOL):   rdata_out <= ccfg_r[0].vol;
				R_TOT1 | 5'(T_VOL):   rdata_out <= ccfg_r[1].vol;
				default: rdata_out <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);

	relay_follow_a: assert property ((lo_ev_r || hi_ev_r) |=>
		switched_output_relay_out)
		else $error("relay not driven by alarm");
	disabled_quiet_a: assert property (!tcfg_r.en |=>
		!lo_ev_r && !hi_ev_r)
		else $error("event while alarm disabled");
	lock_ignore_a: assert property (lock_r |->
		clr_req == 2'b00)
		else $error("reset accepted while locked");
	clear_confirm_a: assert property (clr_req[0] |=>
		tot_r[0] == 32'h0 && confirm_r[0])
		else $error("reset not performed");
	save_tick_a: assert property (tick_r && loaded_r |=>
		nv_save_out)
		else $error("total not saved");
	tot_hold_a: assert property (loaded_r && !ccfg_r[0].en &&
		!ccfg_r[0].arst && !clr_req[0] |=> tot_r[0] == $past(tot_r[0]))
		else $error("disabled total moved");

endmodule

// ### sim/tafl_nv_model.sv
// tafl_nv_model: nonvolatile store standing behind the totals
// assumes save strobe and packed totals registered on mclk_in
`timescale 1ns/1ps
module tafl_nv_model #(
	parameter logic [31:0] INIT0 = 32'h00000100,
	parameter logic [31:0] INIT1 = 32'h00000200
) (
	// clock
	input  wire logic        mclk_in,
	// save side
	input  wire logic        nv_save_in,
	input  wire logic [63:0] nv_data_in,
	// reload side
	output logic      [31:0] nv_tot0_out,
	output logic      [31:0] nv_tot1_out
);
	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	logic [63:0] store_r;

	// save and reload
	// contents survive device resets, like the real store
	initial store_r = {INIT1, INIT0};
	always @(posedge mclk_in) begin
		if (nv_save_in === 1'b1) begin
			store_r <= nv_data_in;
		end
	end
	assign nv_tot0_out = store_r[31:0];
	assign nv_tot1_out = store_r[63:32];
endmodule

// ### sim/tb.sv
// tb: self-checking bench for temperature alarm and totalizers
// assumes tafl_top with a short second and the nv store model
`timescale 1ns/1ps
module tb;
	import tafl_pkg::*;
	localparam int          SC    = 10;
	localparam int          LIMIT = 20000;
	localparam logic [31:0] I0    = 32'h00000100;
	localparam logic [31:0] I1    = 32'h00000200;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic               mclk_in, reset_in, wr_in, rd_in, maint_btn_in;
	logic        [4:0]  addr_in;
	logic        [31:0] wdata_in, rdata_out, nv_tot0_in, nv_tot1_in;
	logic signed [15:0] temp_in;
	logic        [9:0]  flow_pm_in;
	logic        [15:0] flow_rate_in, rate;
	logic               nv_save_out, relay, tlo, thi, alert, a0;
	logic        [63:0] nv_data_out;
	logic        [1:0]  tot_ev, confirm;
	logic        [31:0] seed, v, d0, d1, va, vb;
	int                 err_count, checks_done, cyc, i, t;

	tafl_top #(.SEC_CNT(SC)) dut (.mclk_in, .reset_in, .addr_in,
		.wdata_in, .wr_in, .rd_in, .rdata_out, .temp_in, .flow_pm_in,
		.flow_rate_in, .maint_btn_in, .nv_tot0_in, .nv_tot1_in,
		.nv_save_out, .nv_data_out, .switched_output_relay_out(relay),
		.tlo_event_out(tlo), .thi_event_out(thi), .alert_marker_out(alert),
		.tot_event_out(tot_ev), .rst_confirm_out(confirm));
	tafl_nv_model #(.INIT0(I0), .INIT1(I1)) nv (.mclk_in,
		.nv_save_in(nv_save_out), .nv_data_in(nv_data_out),
		.nv_tot0_out(nv_tot0_in), .nv_tot1_out(nv_tot1_in));

	// clock and hang guard
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_count++;
			final_report();
		end
	end
	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [4:0] ta(input logic k, input logic [2:0] o);
		return (k ? R_TOT1 : R_TOT0) | {2'h0, o};
	endfunction
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge mclk_in);
		wr_in    <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge mclk_in);
		rd_in   <= 1'b0;
		#1 d = rdata_out;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk_w(d, exp);
	endtask
	// wait for a chosen flag under a bound, then expect it high
	task automatic wbit(input int s, input int lim);
		int   n;
		logic c;
		n = 0;
		c = 1'b0;
		while (c !== 1'b1 && n < lim) begin
			@(posedge mclk_in);
			#1 n++;
			case (s)
				0: c = nv_save_out;
				1: c = tot_ev[0];
				2: c = tlo;
				default: c = confirm[0];
			endcase
		end
		chk_b(c, 1'b1);
	endtask
	task automatic tchk(input logic lo, input logic hi, input logic rl);
		repeat (4) @(posedge mclk_in);
		#1 chk_b(tlo, lo);
		chk_b(thi, hi);
		chk_b(relay, rl);
	endtask
	// one second of totals, reads aligned to the save pulse
	task automatic msr();
		wbit(0, 2 * SC);
		rd(ta(0, T_VALUE), va);
		rd(ta(1, T_VALUE), vb);
		wbit(0, 2 * SC);
		rd(ta(0, T_VALUE), d0);
		rd(ta(1, T_VALUE), d1);
		d0 = d0 - va;
		d1 = d1 - vb;
	endtask
	task automatic press();
		@(posedge mclk_in);
		maint_btn_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		maint_btn_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		{reset_in, wr_in, rd_in, maint_btn_in} = 4'h8;
		{addr_in, wdata_in, flow_pm_in, flow_rate_in} = '0;
		temp_in = 16'sh0032;
		seed = 32'hFF331A2E;
		{err_count, checks_done, cyc} = '0;
		repeat (2) @(posedge mclk_in);
		reset_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rdc(R_TCTRL, 32'h0);
		rdc(ta(0, T_CTRL), 32'h0);
		rdc(R_LOCK, 32'h0);
		rdc(ta(0, T_VALUE), I0);
		rdc(ta(1, T_VALUE), I1);
		// limits clamp to their ranges
		for (i = 0; i < 4; i++) begin
			wr(i < 2 ? R_TLO : R_THI, i[0] ? 32'h7FFF : 32'h8000);
			rd(i < 2 ? R_TLO : R_THI, v);
			chk_w({16'h0, v[15:0]}, {16'h0, i == 0 ? TLO_MIN : i == 1 ?
				TLO_MAX : i == 2 ? THI_MIN : THI_MAX});
		end
		wr(R_TLO, 32'h0);
		wr(R_THI, 32'h64);
		temp_in <= -16'sd50;
		tchk(1'b0, 1'b0, 1'b0);
		wr(R_TCTRL, 32'h1);
		for (i = 0; i < 40; i++) begin
			t = i == 0 ? 0 : i == 1 ? 100 : i == 2 ? -1 : i == 3 ? 101 :
				int'(rnd() % 1100) - 300;
			temp_in <= 16'(t);
			tchk(t < 0, t > 100, t < 0 || t > 100);
		end
		temp_in <= -16'sd50;
		tchk(1'b1, 1'b0, 1'b1);
		a0 = alert;
		repeat (SC) @(posedge mclk_in);
		#1 chk_b(alert, ~a0);
		$display("alarm test done");
		temp_in <= 16'sd50;
		wr(R_TACT, 32'h2);
		temp_in <= -16'sd50;
		repeat (SC - 2) @(posedge mclk_in);
		#1 chk_b(tlo, 1'b0);
		wbit(2, 3 * SC);
		temp_in <= 16'sd50;
		wr(R_TACT, 32'h0);
		wr(R_TCTRL, 32'h3);
		temp_in <= 16'sd200;
		tchk(1'b0, 1'b1, 1'b1);
		temp_in <= 16'sd50;
		tchk(1'b0, 1'b0, 1'b1);
		wr(R_TCTRL, 32'h1);
		tchk(1'b0, 1'b0, 1'b0);
		wr(R_TPON, 32'hFFFF);
		rdc(R_TPON, 32'(DLY_MAX_S));
		temp_in <= -16'sd50;
		tchk(1'b0, 1'b0, 1'b0);
		wr(R_TPON, 32'h0);
		tchk(1'b1, 1'b0, 1'b1);
		temp_in <= 16'sd50;
		$display("delay and latch test done");
		rate = 16'(rnd() % 200 + 1);
		flow_rate_in <= rate;
		flow_pm_in <= 10'd499;
		wr(ta(0, T_START), 32'd500);
		wr(ta(0, T_CTRL), 32'h1);
		msr();
		chk_w(d0, 32'h0);
		chk_w(d1, 32'h0);
		wr(ta(1, T_PON), 32'hE10);
		wr(ta(1, T_CTRL), 32'h1);
		flow_pm_in <= 10'd500;
		msr();
		chk_w(d0, 32'(rate));
		chk_w(d1, 32'h0);
		chk_w(nv_tot1_in, I1);
		chk_b(tot_ev[1], 1'b0);
		rd(ta(0, T_VALUE), v);
		wr(ta(0, T_VOL), v + 32'(rate) * 2);
		wbit(1, 4 * SC);
		flow_pm_in <= 10'd0;
		wr(ta(0, T_CMD), 32'h1);
		wbit(3, 4);
		rdc(ta(0, T_VALUE), 32'h0);
		chk_b(tot_ev[0], 1'b0);
		$display("totalizer test done");
		wr(R_LOCK, 32'h1);
		rdc(R_LOCK, 32'h0);
		wr(R_LOCK, {LOCK_KEY, 16'h0001});
		rdc(R_LOCK, 32'h1);
		wr(ta(1, T_CMD), 32'h1);
		press();
		rdc(ta(1, T_VALUE), I1);
		wr(R_LOCK, {LOCK_KEY, 16'h0000});
		press();
		rdc(ta(1, T_VALUE), 32'h0);
		wr(ta(0, T_VOL), 32'(rate) * 3);
		wr(ta(0, T_ARDLY), 32'h3);
		wr(ta(0, T_CTRL), 32'h3);
		flow_pm_in <= 10'd600;
		wbit(1, 6 * SC);
		rd(ta(0, T_VALUE), v);
		chk_b(v < 32'(rate) * 3, 1'b1);
		repeat (SC) @(posedge mclk_in);
		rdc(ta(0, T_VALUE), 32'h0);
		repeat (3 * SC) @(posedge mclk_in);
		rd(ta(0, T_VALUE), v);
		chk_b(v != 32'h0, 1'b1);
		$display("reset and lock test done");
		flow_pm_in <= 10'd0;
		wbit(0, 2 * SC);
		wbit(0, 2 * SC);
		rd(ta(0, T_VALUE), va);
		reset_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		reset_in <= 1'b0;
		rdc(ta(0, T_VALUE), va);
		rdc(ta(1, T_VALUE), 32'h0);
		rdc(R_TCTRL, 32'h0);
		$display("reload test done");
		final_report();
	end
endmodule
